// ---- include/nand_host_pkg.sv ----
/*
  Shared constants and types for the NAND identification host controller.
  Assumes a 200 MHz system clock and an 8-bit multiplexed NAND bus.
*/
package nand_host_pkg;
  localparam int CLK_MHZ = 200;
  localparam int T_WB_NS = 100;
  localparam int WB_CYC  = (T_WB_NS * CLK_MHZ + 999) / 1000;
  localparam int PP_LEN  = 92;
  localparam int ID_LEN  = 5;
  localparam int SIG_LEN = 4;

  localparam logic [7:0] CMD_ID     = 8'h90;
  localparam logic [7:0] CMD_RESET  = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_PARAM  = 8'hec;
  localparam logic [7:0] CMD_READ   = 8'h00;
  localparam logic [7:0] CMD_COL    = 8'h05;
  localparam logic [7:0] CMD_COL_GO = 8'he0;
  localparam logic [7:0] ADR_ID     = 8'h00;
  localparam logic [7:0] ADR_SIG    = 8'h20;
  localparam logic [31:0] SIG_WORD  = 32'h49464e4f;
  localparam logic [7:0] ST_RESET   = 8'he0;
  localparam logic [7:0] ST_WP_MASK = 8'h80;

  localparam int PP_REV   = 4;
  localparam int PP_FEAT  = 6;
  localparam int PP_OPT   = 8;
  localparam int PP_RA_LO = 10;
  localparam int PP_RA_HI = 31;
  localparam int PP_MAKER = 64;
  localparam int PP_RB_LO = 67;
  localparam int PP_RB_HI = 79;
  localparam int PP_PAGE  = 80;
  localparam int PP_SPARE = 84;
  localparam int PP_PPAGE = 86;
  localparam int PP_PSPR  = 90;
  localparam logic [15:0] REV_V10 = 16'h0002;

  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_STAT    = 5'h01;
  localparam logic [4:0] REG_ID0     = 5'h02;
  localparam logic [4:0] REG_ID1     = 5'h03;
  localparam logic [4:0] REG_IDDEC0  = 5'h04;
  localparam logic [4:0] REG_IDDEC1  = 5'h05;
  localparam logic [4:0] REG_SIG     = 5'h06;
  localparam logic [4:0] REG_COL     = 5'h07;
  localparam logic [4:0] REG_PPIDX   = 5'h08;
  localparam logic [4:0] REG_PPDATA  = 5'h09;
  localparam logic [4:0] REG_PPREV   = 5'h0a;
  localparam logic [4:0] REG_PPOPT   = 5'h0b;
  localparam logic [4:0] REG_PPPAGE  = 5'h0c;
  localparam logic [4:0] REG_PPSPARE = 5'h0d;
  localparam logic [4:0] REG_PPPART  = 5'h0e;
  localparam logic [4:0] REG_PPUNITS = 5'h0f;

  typedef enum logic [2:0] {OP_NONE = 3'h0, OP_RESET = 3'h1, OP_ID = 3'h2, OP_SIG = 3'h3,
    OP_PARAM = 3'h4, OP_COLUMN = 3'h5, OP_STATUS = 3'h6} op_t;
  typedef enum logic [1:0] {CY_CMD = 2'h0, CY_ADDR = 2'h1, CY_READ = 2'h2} cyc_t;
  typedef enum logic [1:0] {CP_IDLE = 2'h0, CP_SETUP = 2'h1, CP_LOW = 2'h2,
    CP_HOLD = 2'h3} cph_t;
  typedef enum logic [2:0] {SK_CMD = 3'h0, SK_ADDR = 3'h1, SK_WB = 3'h2, SK_RDY = 3'h3,
    SK_READ = 3'h4, SK_END = 3'h5} step_t;
  typedef enum logic [2:0] {H_IDLE = 3'h0, H_ISSUE = 3'h1, H_CYC = 3'h2, H_WB = 3'h3,
    H_RDY = 3'h4} hfsm_t;
  typedef struct packed {
    step_t      k;
    logic [7:0] b;
  } stp_t;
endpackage

// ---- hw/nand_cycle.sv ----
/*
  One NAND bus cycle: command latch, address latch or data read.
  Assumes tick is a one-cycle enable that paces every pin phase.
*/
`timescale 1ns/1ps
module nand_cycle import nand_host_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Request
  input  wire logic       tick,
  input  wire logic       start,
  input  wire cyc_t       kind,
  input  wire logic [7:0] wbyte,
  output logic            done,
  output logic [7:0]      rbyte,
  // Pins
  output logic            cle,
  output logic            ale,
  output logic            we_n,
  output logic            re_n,
  input  wire logic [7:0] dq_in,
  output logic [7:0]      dq_out,
  output logic            dq_oe
);
  typedef struct packed {
    cph_t       ph;
    cyc_t       kind;
    logic [7:0] dq;
    logic [7:0] rb;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       oe;
    logic       done;
  } cs_t;

  cs_t c_r;
  cs_t c_nxt;

  // Pins are registered so strobes never glitch
  always_comb begin
    c_nxt = c_r;
    c_nxt.done = 1'b0;
    case (c_r.ph)
      CP_IDLE: if (start) begin
        c_nxt.ph = CP_SETUP;
        c_nxt.kind = kind;
        c_nxt.dq = wbyte;
        c_nxt.cle = (kind == CY_CMD);
        c_nxt.ale = (kind == CY_ADDR);
        c_nxt.oe = (kind != CY_READ);
      end
      CP_SETUP: if (tick) begin
        c_nxt.ph = CP_LOW;
        c_nxt.re_n = (c_r.kind != CY_READ);
        c_nxt.we_n = (c_r.kind == CY_READ);
      end
      CP_LOW: if (tick) begin
        c_nxt.ph = CP_HOLD;
        c_nxt.we_n = 1'b1;
        c_nxt.re_n = 1'b1;
        if (c_r.kind == CY_READ) begin
          c_nxt.rb = dq_in;
        end
      end
      CP_HOLD: if (tick) begin
        c_nxt.ph = CP_IDLE;
        c_nxt.cle = 1'b0;
        c_nxt.ale = 1'b0;
        c_nxt.oe = 1'b0;
        c_nxt.done = 1'b1;
      end
      default: c_nxt.ph = CP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      c_r <= '{CP_IDLE, CY_CMD, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    end else begin
      c_r <= c_nxt;
    end
  end

  assign done   = c_r.done;
  assign rbyte  = c_r.rb;
  assign cle    = c_r.cle;
  assign ale    = c_r.ale;
  assign we_n   = c_r.we_n;
  assign re_n   = c_r.re_n;
  assign dq_out = c_r.dq;
  assign dq_oe  = c_r.oe;
endmodule // nand_cycle

// ---- hw/id_decode.sv ----
/*
  Decoder of the fourth and fifth identifier bytes into register words.
  Assumes the bytes are held stable by the caller.
*/
`timescale 1ns/1ps
module id_decode (
  // Identifier bytes
  input  wire logic [7:0] id4,
  input  wire logic [7:0] id5,
  // Decoded words
  output logic [31:0]     dec0,
  output logic [31:0]     dec1
);
  logic [15:0] page_bytes;
  logic [15:0] block_kb;
  logic [5:0]  spare;
  logic [3:0]  ecc;
  logic [3:0]  planes;
  logic [13:0] plane_mbit;

  assign page_bytes = 16'h0400 << id4[1:0];
  assign block_kb   = 16'h0040 << id4[5:4];
  assign spare      = id4[2] ? 6'h20 : 6'h10;
  assign ecc        = 4'h1 << id5[1:0];
  assign planes     = 4'h1 << id5[3:2];
  assign plane_mbit = 14'h0040 << id5[6:4];

  assign dec0 = {block_kb, page_bytes};
  assign dec1 = {~id5[7], id4[7], id4[3], id4[6], spare, ecc, planes, plane_mbit};
endmodule // id_decode

// ---- hw/nand_host.sv ----
/*
  Host controller that drives a NAND device for identification, signature,
  reset, status and parameter page reads; software uses Avalon-MM registers.
  Assumes the NAND pins are synchronous to clk and one device on the bus.
*/
`timescale 1ns/1ps
module nand_host import nand_host_pkg::*; #(
  parameter int DIV          = 4,
  parameter int BUSY_TIMEOUT = 2000000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // NAND pins
  output logic             ce_n,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             read_strobe_n,
  output logic             wp_n,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  input  wire logic        ready_busy_n
);
  localparam int TMR_W = $clog2(BUSY_TIMEOUT + 1);

  if (DIV < 2 || DIV > 255 || BUSY_TIMEOUT <= WB_CYC) begin : g_bad_param
    $error("nand_host: DIV or BUSY_TIMEOUT out of range");
  end

  typedef struct packed {
    hfsm_t                   fsm;
    op_t                     op;
    logic [3:0]              step;
    logic [6:0]              cnt;
    logic [7:0]              col;
    logic [6:0]              pp_idx;
    logic [TMR_W-1:0]        tmr;
    logic [7:0]              div;
    logic [ID_LEN-1:0][7:0]  id;
    logic [SIG_LEN-1:0][7:0] sig;
    logic [PP_LEN-1:0][7:0]  pp;
    logic [7:0]              stat;
    cyc_t                    ckind;
    logic [7:0]              cbyte;
    logic                    go;
    logic                    in_pp;
    logic                    pp_valid;
    logic                    done;
    logic                    tmo;
    logic                    refused;
    logic                    rst_ok;
    logic                    wp_n;
    logic                    x16;
    logic                    ce_n;
    logic                    ack;
    logic [31:0]             rdata;
  } st_t;

  st_t         s_r;
  st_t         s_nxt;
  stp_t        cur;
  logic        tick;
  logic        cyc_done;
  logic [7:0]  cyc_rbyte;
  logic [31:0] dec0;
  logic [31:0] dec1;
  logic [2:0]  req_op;
  logic        op_take;

  // Step list of each operation
  function automatic stp_t step_of(input op_t op, input logic [3:0] i,
                                   input logic [7:0] col, input logic in_pp);
    stp_t s;
    s = '{SK_END, 8'h00};
    case (op)
      OP_RESET: case (i)
        4'h0: s = '{SK_CMD, CMD_RESET};
        4'h1: s = '{SK_WB, 8'h00};
        4'h2: s = '{SK_RDY, 8'h00};
        4'h3: s = '{SK_CMD, CMD_STATUS};
        4'h4: s = '{SK_READ, 8'h00};
        default: s = '{SK_END, 8'h00};
      endcase
      OP_ID, OP_SIG: case (i)
        4'h0: s = '{SK_CMD, CMD_ID};
        4'h1: s = '{SK_ADDR, (op == OP_SIG) ? ADR_SIG : ADR_ID};
        4'h2: s = '{SK_WB, 8'h00};
        4'h3: s = '{SK_READ, 8'h00};
        default: s = '{SK_END, 8'h00};
      endcase
      OP_PARAM: case (i)
        4'h0: s = '{SK_CMD, CMD_PARAM};
        4'h1: s = '{SK_ADDR, 8'h00};
        4'h2: s = '{SK_WB, 8'h00};
        4'h3: s = '{SK_RDY, 8'h00};
        4'h4: s = '{SK_READ, 8'h00};
        default: s = '{SK_END, 8'h00};
      endcase
      OP_COLUMN: case (i)
        4'h0: s = '{SK_CMD, CMD_COL};
        4'h1: s = '{SK_ADDR, col};
        4'h2: s = '{SK_ADDR, 8'h00};
        4'h3: s = '{SK_CMD, CMD_COL_GO};
        4'h4: s = '{SK_WB, 8'h00};
        4'h5: s = '{SK_READ, 8'h00};
        default: s = '{SK_END, 8'h00};
      endcase
      OP_STATUS: case (i)
        4'h0: s = '{SK_CMD, CMD_STATUS};
        4'h1: s = '{SK_WB, 8'h00};
        4'h2: s = '{SK_READ, 8'h00};
        4'h3: s = in_pp ? stp_t'{SK_CMD, CMD_READ} : stp_t'{SK_END, 8'h00};
        default: s = '{SK_END, 8'h00};
      endcase
      default: s = '{SK_END, 8'h00};
    endcase
    return s;
  endfunction

  // Bytes fetched by the read step; a column read fetches from col up to the last parameter page byte
  function automatic logic [6:0] rd_len(input op_t op, input logic [7:0] col);
    case (op)
      OP_ID:     return 7'(ID_LEN);
      OP_SIG:    return 7'(SIG_LEN);
      OP_PARAM:  return 7'(PP_LEN);
      OP_COLUMN: return 7'(PP_LEN) - col[6:0];
      default:   return 7'h01;
    endcase
  endfunction

  function automatic logic [15:0] le16(input logic [PP_LEN-1:0][7:0] p, input int b);
    return {p[b+1], p[b]};
  endfunction

  function automatic logic [31:0] le32(input logic [PP_LEN-1:0][7:0] p, input int b);
    return {le16(p, b + 2), le16(p, b)};
  endfunction

  // Page accepted only if signature, revision and reserved fields are right
  function automatic logic pp_check(input logic [PP_LEN-1:0][7:0] p);
    logic ok;
    ok = (le32(p, 0) == SIG_WORD);
    ok = ok && (le16(p, PP_REV) == REV_V10);
    ok = ok && ((le16(p, PP_FEAT) >> 5) == 16'h0000);
    ok = ok && ((le16(p, PP_OPT) >> 6) == 16'h0000);
    for (int k = PP_RA_LO; k <= PP_RA_HI; k++) begin
      ok = ok && (p[k] == 8'h00);
    end
    for (int k = PP_RB_LO; k <= PP_RB_HI; k++) begin
      ok = ok && (p[k] == 8'h00);
    end
    return ok;
  endfunction

  assign tick   = (s_r.div == 8'(DIV - 1));
  assign cur    = step_of(s_r.op, s_r.step, s_r.col, s_r.in_pp);
  assign req_op = avs_writedata[2:0];

  always_comb begin
    s_nxt = s_r;
    op_take = 1'b0;
    s_nxt.go = 1'b0;
    s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    case (s_r.fsm)
      H_IDLE: s_nxt.ce_n = 1'b1;
      H_ISSUE: begin
        s_nxt.tmr = '0;
        case (cur.k)
          SK_CMD, SK_ADDR, SK_READ: begin
            s_nxt.go = 1'b1;
            s_nxt.ckind = (cur.k == SK_CMD) ? CY_CMD : (cur.k == SK_ADDR) ? CY_ADDR : CY_READ;
            s_nxt.cbyte = cur.b;
            s_nxt.fsm = H_CYC;
          end
          SK_WB: s_nxt.fsm = H_WB;
          SK_RDY: s_nxt.fsm = H_RDY;
          default: begin
            s_nxt.fsm = H_IDLE;
            s_nxt.op = OP_NONE;
            s_nxt.done = 1'b1;
            if (s_r.op == OP_PARAM || s_r.op == OP_COLUMN) begin
              s_nxt.in_pp = 1'b1;
              s_nxt.pp_valid = 1'b1;
            end
            if (s_r.op == OP_RESET) begin
              s_nxt.in_pp = 1'b0;
              s_nxt.rst_ok = (s_r.stat == (s_r.wp_n ? ST_RESET : (ST_RESET & ~ST_WP_MASK)));
            end
          end
        endcase
      end
      H_CYC: if (cyc_done) begin
        s_nxt.fsm = H_ISSUE;
        if (s_r.ckind == CY_READ) begin
          case (s_r.op)
            OP_ID: s_nxt.id[s_r.cnt[2:0]] = cyc_rbyte;
            OP_SIG: s_nxt.sig[s_r.cnt[1:0]] = cyc_rbyte;
            OP_PARAM: s_nxt.pp[s_r.cnt] = cyc_rbyte;
            OP_COLUMN: s_nxt.pp[s_r.cnt + s_r.col[6:0]] = cyc_rbyte;
            default: s_nxt.stat = cyc_rbyte;
          endcase
          s_nxt.cnt = s_r.cnt + 7'h01;
          if (s_r.cnt + 7'h01 == rd_len(s_r.op, s_r.col)) begin
            s_nxt.step = s_r.step + 4'h1;
            s_nxt.cnt = '0;
          end
        end else begin
          s_nxt.step = s_r.step + 4'h1;
        end
      end
      H_WB: begin
        s_nxt.tmr = s_r.tmr + 1'b1;
        if (s_r.tmr == TMR_W'(WB_CYC - 1)) begin
          s_nxt.step = s_r.step + 4'h1;
          s_nxt.fsm = H_ISSUE;
        end
      end
      H_RDY: begin
        s_nxt.tmr = s_r.tmr + 1'b1;
        if (ready_busy_n) begin
          s_nxt.step = s_r.step + 4'h1;
          s_nxt.fsm = H_ISSUE;
        end else if (s_r.tmr == TMR_W'(BUSY_TIMEOUT - 1)) begin
          s_nxt.tmo = 1'b1;
          s_nxt.done = 1'b1;
          s_nxt.in_pp = 1'b0;
          s_nxt.op = OP_NONE;
          s_nxt.fsm = H_IDLE;
        end
      end
      default: s_nxt.fsm = H_IDLE;
    endcase

    // Register writes take effect on the release edge, one cycle after the edge that ends the wait state
    if (avs_write && s_r.ack) begin
      case (avs_address)
        REG_CTRL: begin
          s_nxt.wp_n = avs_writedata[8];
          s_nxt.x16 = avs_writedata[9];
          if (req_op != 3'h0) begin
            if (s_r.op == OP_NONE && !(op_t'(req_op) == OP_COLUMN && !s_r.in_pp)
                && req_op <= 3'h6) begin
              s_nxt.op = op_t'(req_op);
              s_nxt.fsm = H_ISSUE;
              op_take = 1'b1;
            end else if (op_t'(req_op) == OP_RESET && s_r.op != OP_RESET
                         && (s_r.fsm == H_WB || s_r.fsm == H_RDY)) begin
              s_nxt.op = OP_RESET;
              s_nxt.fsm = H_ISSUE;
              op_take = 1'b1;
            end else begin
              s_nxt.refused = 1'b1;
            end
            // Only an accepted op restarts; a refused one must not touch the running op
            if (op_take) begin
              s_nxt.step = '0;
              s_nxt.cnt = '0;
              s_nxt.ce_n = 1'b0;
              s_nxt.done = 1'b0;
              s_nxt.tmo = 1'b0;
              s_nxt.refused = 1'b0;
            end
          end
        end
        REG_COL: if (avs_writedata[7:0] < 8'(PP_LEN)) begin
          s_nxt.col = avs_writedata[7:0];
        end
        REG_PPIDX: s_nxt.pp_idx = avs_writedata[6:0];
        default: ;
      endcase
    end

    // Read data is loaded in the first cycle and stands at the release edge
    if (avs_read && !s_r.ack) begin
      case (avs_address)
        REG_CTRL: s_nxt.rdata = {22'h0, s_r.x16, s_r.wp_n, 5'h0, s_r.op};
        REG_STAT: s_nxt.rdata = {12'h0, ready_busy_n, s_r.stat[0], s_r.stat[7], s_r.stat[6],
                                 s_r.stat, s_r.in_pp, s_r.refused, s_r.tmo, s_r.rst_ok,
                                 s_r.pp_valid && pp_check(s_r.pp), s_r.sig == SIG_WORD,
                                 s_r.done, s_r.op != OP_NONE};
        REG_ID0: s_nxt.rdata = s_r.id[3:0];
        REG_ID1: s_nxt.rdata = {24'h0, s_r.id[4]};
        REG_IDDEC0: s_nxt.rdata = dec0;
        REG_IDDEC1: s_nxt.rdata = dec1;
        REG_SIG: s_nxt.rdata = s_r.sig;
        REG_COL: s_nxt.rdata = {24'h0, s_r.col};
        REG_PPIDX: s_nxt.rdata = {25'h0, s_r.pp_idx};
        REG_PPDATA: s_nxt.rdata = (s_r.pp_idx < 7'(PP_LEN)) ? {24'h0, s_r.pp[s_r.pp_idx]} : '0;
        REG_PPREV: s_nxt.rdata = {le16(s_r.pp, PP_FEAT), le16(s_r.pp, PP_REV)};
        REG_PPOPT: s_nxt.rdata = {8'h0, s_r.pp[PP_MAKER], le16(s_r.pp, PP_OPT)};
        REG_PPPAGE: s_nxt.rdata = le32(s_r.pp, PP_PAGE);
        REG_PPSPARE: s_nxt.rdata = {le16(s_r.pp, PP_PSPR), le16(s_r.pp, PP_SPARE)};
        REG_PPPART: s_nxt.rdata = le32(s_r.pp, PP_PPAGE);
        REG_PPUNITS: s_nxt.rdata = s_r.x16 ? (le32(s_r.pp, PP_PAGE) >> 1)
                                           : le32(s_r.pp, PP_PAGE);
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.wp_n <= 1'b1;
      s_r.ce_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  nand_cycle u_cycle (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick),
    .start  (s_r.go),
    .kind   (s_r.ckind),
    .wbyte  (s_r.cbyte),
    .done   (cyc_done),
    .rbyte  (cyc_rbyte),
    .cle    (cle),
    .ale    (ale),
    .we_n   (we_n),
    .re_n   (read_strobe_n),
    .dq_in  (dq_in),
    .dq_out (dq_out),
    .dq_oe  (dq_oe)
  );

  id_decode u_dec (
    .id4  (s_r.id[3]),
    .id5  (s_r.id[4]),
    .dec0 (dec0),
    .dec1 (dec1)
  );

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
  assign ce_n            = s_r.ce_n;
  assign wp_n            = s_r.wp_n;
endmodule // nand_host

// ---- bench/nand_host_properties.sv ----
/* Port checker of the NAND host controller.
   Assumes one clock domain and the register map of the package. */
`timescale 1ns/1ps
module nand_host_properties import nand_host_pkg::*; #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Avalon-MM
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // NAND pins
  input wire logic        ce_n,
  input wire logic        cle,
  input wire logic        ale,
  input wire logic        we_n,
  input wire logic        read_strobe_n,
  input wire logic        wp_n,
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe,
  input wire logic        ready_busy_n
);
  // Enhanced status opcode; the host must never send it
  localparam logic [7:0] CMD_ENH = 8'h78;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  int   lo_r;
  logic wp_r;
  // Strobes never overlap, so one counter serves both
  always_ff @(posedge clk) begin
    lo_r <= (we_n && read_strobe_n) ? 0 : lo_r + 1;
    if (!resetn) wp_r <= 1'b1;
    else if (avs_write && !avs_waitrequest && avs_address == REG_CTRL) wp_r <= avs_writedata[8];
  end
  sequence s_req; $rose(avs_read || avs_write); endsequence
  sequence s_ctrl; avs_write && !avs_waitrequest && avs_address == REG_CTRL; endsequence
  a_one_wait: assert property (s_req |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  a_strobe_len: assert property (($rose(we_n) || $rose(read_strobe_n)) |-> lo_r == DIV)
    else $error("strobe low time wrong");
  a_wp_follow: assert property (s_ctrl |-> ##[1:3] wp_n == wp_r)
    else $error("write protect pin wrong");
  a_no_enhanced: assert property (cle && !we_n |-> dq_out != CMD_ENH)
    else $error("enhanced status sent");
  a_latch_drive: assert property ((cle || ale) && !we_n |-> dq_oe && !ce_n)
    else $error("latch cycle not driven");
  a_read_ready: assert property ($fell(read_strobe_n) |-> ready_busy_n && !ce_n && !dq_oe)
    else $error("read while busy or driving");
  a_one_strobe: assert property (!(!we_n && !read_strobe_n) && !(cle && ale))
    else $error("strobes overlap");
  a_hold_data: assert property ($rose(we_n) |=> $stable({cle, ale, dq_out})[*2])
    else $error("latch hold broken");
endmodule // nand_host_properties

bind nand_host nand_host_properties #(.DIV(DIV)) i_nand_host_properties (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
  .wp_n(wp_n), .dq_out(dq_out), .dq_oe(dq_oe), .ready_busy_n(ready_busy_n));

// ---- bench/nand_dev_model.sv ----
/* Behavioural NAND device: identify, signature, reset, status, parameter page.
   Assumes host pins change on clk edges; one device on the bus. */
`timescale 1ns/1ps
module nand_dev_model import nand_host_pkg::*; #(
  parameter int RST_CYC = 60
) (
  // Host pins
  input  wire logic       clk,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] dq_out,
  // Device pins
  output logic [7:0]      dq_in = 8'h00,
  output logic            ready_busy_n
);
  logic [39:0] id = 40'h581511225a; // First three bytes arbitrary
  logic [7:0]  pp [PP_LEN];
  logic [7:0]  cmd = 0, ptr = 0;
  logic        sig = 0, stat = 0, rst = 0, colf = 0, we_q = 1, re_q = 1;
  int          busy = 0;
  initial begin
    for (int i = 0; i < PP_LEN; i++) pp[i] = (i >= 32 && i < 64) ? 8'h41 : 8'h00;
    {pp[3], pp[2], pp[1], pp[0]} = 32'h49464e4f;
    pp[4] = 8'h02; pp[6] = 8'h18; pp[8] = 8'h07; pp[64] = 8'h5a;
    pp[81] = 8'h08; pp[84] = 8'h40; pp[87] = 8'h02; pp[90] = 8'h10;
  end
  assign ready_busy_n = (busy == 0);
  always @(posedge clk) begin
    we_q <= we_n;
    re_q <= read_strobe_n;
    if (busy > 0) busy <= busy - 1;
    if (we_n && !we_q && !ce_n && cle) begin
      if (dq_out == CMD_RESET) begin
        if (!rst || busy == 0) begin
          busy <= RST_CYC; rst <= 1; cmd <= 0; stat <= 0;
        end
      end else begin
        stat <= (dq_out == CMD_STATUS);
        if (dq_out == CMD_ID || dq_out == CMD_PARAM) cmd <= dq_out;
        if (dq_out == CMD_COL) colf <= 1;
        if (dq_out == CMD_PARAM) begin
          busy <= 40; rst <= 0; ptr <= 0;
        end
      end
    end
    if (we_n && !we_q && !ce_n && ale) begin
      if (colf) begin
        ptr <= dq_out; colf <= 0;
      end else if (cmd == CMD_ID) begin
        sig <= (dq_out == ADR_SIG); ptr <= 0;
      end
    end
    if (!read_strobe_n && re_q && !ce_n) begin
      ptr <= ptr + 1;
      if (stat) dq_in <= {wp_n, ready_busy_n, ready_busy_n, 5'h0};
      else if (cmd == CMD_ID && sig) dq_in <= ptr < 4 ? 8'(32'h49464e4f >> 8*ptr) : ~ptr;
      else if (cmd == CMD_ID) dq_in <= 8'(id >> 8*ptr);
      else dq_in <= ptr < PP_LEN ? pp[ptr] : ~ptr;
    end
    // Released bus shows no stale byte
    if (read_strobe_n && !re_q) dq_in <= ~dq_in;
  end
endmodule // nand_dev_model

// ---- bench/nand_host_test.sv ----
/* Register-level test of the NAND host controller with a device model.
   Assumes DIV 4 and a shortened ready timeout. */
`timescale 1ns/1ps
module nand_host_test import nand_host_pkg::*; ;
  logic        clk = 0, resetn = 0, rd = 0, wr = 0;
  logic [4:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [7:0]  dq_in, dq_out;
  logic        wreq, ce_n, cle, ale, we_n, re_n, wp_n, dq_oe, rb_n;
  int          mismatches = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  nand_host #(.DIV(4), .BUSY_TIMEOUT(200)) i_nand_host (.clk(clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .read_strobe_n(re_n), .wp_n(wp_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .ready_busy_n(rb_n));
  nand_dev_model i_nand_dev_model (.clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .read_strobe_n(re_n), .wp_n(wp_n), .dq_out(dq_out), .dq_in(dq_in),
    .ready_busy_n(rb_n));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waitrequest and read data are taken at the rising edge, before it updates them
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a; wdat <= d; rd <= !w; wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin mismatches++; summarize(); end
    q = rdat;
    rd <= 0; wr <= 0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk(q, e);
  endtask
  task automatic op(input logic [2:0] c, input logic wp);
    int n;
    n = 0;
    acc(1, REG_CTRL, {22'h0, 1'b0, wp, 5'h0, c});
    do begin acc(0, REG_STAT, 0); n++; end while (q[0] !== 1'b0 && n < 1000);
    if (n >= 1000) begin mismatches++; summarize(); end
  endtask
  task automatic ppchk(input int lo);
    for (int i = lo; i < PP_LEN; i++) begin
      acc(1, REG_PPIDX, 32'(i));
      rchk(REG_PPDATA, {24'h0, i_nand_dev_model.pp[i]});
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1;
    acc(1, 5'h12, 32'h5); rchk(5'h12, 32'h0);
    acc(1, REG_CTRL, 32'h101); op(OP_RESET, 1);
    chk(32'(q[6]), 32'h1);
    chk({q[19:16], q[15:8], 3'h0, q[4]}, {4'hb, 8'he0, 4'h1});
    $display("test reset done");
    op(OP_ID, 1); rchk(REG_ID0, 32'h1511225a); rchk(REG_ID1, 32'h58);
    rchk(REG_IDDEC0, {16'd128, 16'd2048});
    rchk(REG_IDDEC1, {1'b1, 3'h0, 6'd32, 4'd1, 4'd4, 14'd2048});
    $display("test identify done");
    op(OP_SIG, 1); chk(32'(q[2]), 32'h1); rchk(REG_SIG, 32'h49464e4f);
    $display("test signature done");
    op(OP_PARAM, 1); chk({q[7], q[3]}, 2'b11); ppchk(0);
    rchk(REG_PPREV, 32'h00180002); rchk(REG_PPOPT, 32'h005a0007);
    rchk(REG_PPPAGE, 32'd2048); rchk(REG_PPSPARE, {16'd16, 16'd64});
    rchk(REG_PPPART, 32'd512); rchk(REG_PPUNITS, 32'd2048);
    acc(1, REG_CTRL, 32'h300); rchk(REG_CTRL, 32'h300); rchk(REG_PPUNITS, 32'd1024);
    $display("test parameter page done");
    acc(1, REG_COL, 32'd40); acc(1, REG_COL, 32'd92); rchk(REG_COL, 32'd40);
    op(OP_COLUMN, 1); ppchk(40);
    op(OP_STATUS, 1); chk({q[15:8], 7'h0, i_nand_dev_model.stat}, {8'he0, 8'h0});
    $display("test column and status done");
    op(OP_RESET, 0); chk({q[17], q[15:8], 7'h0, wp_n}, {1'b0, 8'h60, 8'h0});
    $display("test protected reset done");
    summarize();
  end
endmodule // nand_host_test
